// *** src/mag_guard.sv ***
/*
  mode and access guard: boot mode selection, segment access with
  open settings and firewall, sfr gating, violation reset request.
  assumes the core holds each access one cycle and obeys the reset.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - test enabled at boot: start factory test code in privileged mode
// - test disabled: start application in unprivileged or privileged mode
// - blown delivery fuse forbids test program whatever the boot inputs
// - three levels: boot above privileged above unprivileged
// - application code never reaches the boot level
// - unprivileged mode cannot touch security fuse settings
// - application code cannot write security feature control bits
// - segment access is full or depends on its open setting
// - open settings reset to most restrictive during boot
// - any error returns all open settings to restrictive default
// - every non-sfr access also passes configurable firewall settings
// - sfr read and write permission from register function and mode
// - forbidden or absent sfr read returns zero and raises security reset
// - access beyond present memory forces a reset
// - inconsistent address is a violation on every access
// - security resets decrement the error counter, reloaded only on the arst_n_in reset
module mag_guard
  import mag_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  // boot straps and fuses
  input wire logic boot_done_in,
  input wire logic test_req_in,
  input wire logic delivery_fuse_in,
  input wire logic app_system_in,
  input wire logic [7:0] fuse_cfg_in,
  // access from the core
  input wire mag_access_t acc_in,
  input wire logic [7:0] sfr_rdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic acc_grant_out,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // status and requests
  output mag_mode_t mode_out,
  output logic test_run_out,
  output logic app_run_out,
  output logic [7:0] secctl_out,
  output logic sec_reset_out,
  output logic irq_out
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic [1:0] seg_of(input logic [15:0] a);
    seg_of = a[15:14];
  endfunction : seg_of

  function automatic logic sfr_allowed(input logic [7:0] idx,
                                       input logic wr,
                                       input mag_mode_t m);
    logic ok;
    ok = 1'b0;
    if (idx <= MAG_SFR_LAST) begin
      if (idx >= MAG_SFR_PRIV_FIRST) begin
        ok = (m != MAG_MODE_USER);
      end else begin
        ok = !wr || (m != MAG_MODE_USER);
      end
    end
    sfr_allowed = ok;
  endfunction : sfr_allowed

  // ------------------------------------------------------------------
  // boot mode selection
  // ------------------------------------------------------------------
  mag_state_t st_q, st_d;
  mag_mode_t mode_q, mode_d;

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    case (st_q)
      MAG_ST_BOOT: begin
        if (boot_done_in) begin
          if (test_req_in && !delivery_fuse_in) begin
            st_d = MAG_ST_TEST;
            mode_d = MAG_MODE_SYSTEM;
          end else begin
            st_d = MAG_ST_APP;
            mode_d = app_system_in ? MAG_MODE_SYSTEM : MAG_MODE_USER;
          end
        end
      end
      MAG_ST_TEST: mode_d = MAG_MODE_SYSTEM;
      MAG_ST_APP: begin
        // application keeps its start mode and never reaches boot level
        if (mode_q == MAG_MODE_SUPER) begin
          mode_d = MAG_MODE_SYSTEM;
        end
      end
      default: begin
        st_d = MAG_ST_BOOT;
        mode_d = MAG_MODE_SUPER;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= MAG_ST_BOOT;
      mode_q <= MAG_MODE_SUPER;
    end else if (clk_en_in) begin
      st_q <= st_d;
      mode_q <= mode_d;
    end
  end

  // ------------------------------------------------------------------
  // access checks
  // ------------------------------------------------------------------
  logic [3:0] open_q, open_d;
  logic [3:0] fw_q, fw_d;
  logic [7:0] secctl_q, secctl_d;
  logic [MAG_NEV-1:0] ev;
  logic [MAG_NSEG-1:0] seg_full;
  logic [1:0] seg;
  logic [7:0] sfr_idx;
  logic sfr_ok;
  logic viol;

  // segment 0 full for all, others need an open setting outside boot
  genvar g;
  generate
    for (g = 0; g < MAG_NSEG; g++) begin : g_seg
      assign seg_full[g] = (g == 0) || (mode_q == MAG_MODE_SUPER);
    end
  endgenerate

  always_comb begin
    seg = seg_of(acc_in.addr);
    sfr_idx = acc_in.addr[7:0];
    sfr_ok = sfr_allowed(sfr_idx, acc_in.write, mode_q);
    ev = '0;
    if (acc_in.valid) begin
      if (acc_in.sfr) begin
        ev[MAG_EV_SFR] = !sfr_ok ||
                         (acc_in.addr[15:8] != MAG_SFR_BASE[15:8]);
      end else begin
        ev[MAG_EV_RANGE] = acc_in.addr > MAG_MEM_TOP;
        ev[MAG_EV_SEG] = !(seg_full[seg] || open_q[seg])
                         || fw_q[seg];
      end
      ev[MAG_EV_CONS] = (acc_in.addr ^ acc_in.addr_chk) != 16'hffff;
    end
    viol = |ev;
  end

  assign acc_grant_out = acc_in.valid && !viol;

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  logic [MAG_NEV-1:0] ist_q, ist_d;
  logic [MAG_NEV-1:0] imask_q, imask_d;
  logic [7:0] errcnt_q, errcnt_d;
  logic sreset_q, sreset_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] sfrd_q, sfrd_d;
  logic priv_w;

  always_comb begin
    priv_w = reg_wr_in && (mode_q == MAG_MODE_SUPER);
    open_d = open_q;
    fw_d = fw_q;
    secctl_d = secctl_q;
    imask_d = imask_q;
    errcnt_d = errcnt_q;
    if (reg_wr_in && mode_q != MAG_MODE_USER &&
        reg_addr_in == MAG_REG_OPEN) begin
      open_d = reg_wdata_in[3:0];
    end
    if (reg_wr_in && mode_q != MAG_MODE_USER &&
        reg_addr_in == MAG_REG_IRQ_MASK) begin
      imask_d = reg_wdata_in[MAG_NEV-1:0];
    end
    if (priv_w && reg_addr_in == MAG_REG_FIREWALL) begin
      fw_d = reg_wdata_in[3:0];
    end
    // security control only from boot level, never from applications
    if (priv_w && reg_addr_in == MAG_REG_SECCTL) begin
      secctl_d = reg_wdata_in & fuse_cfg_in;
    end
    if (viol) begin
      open_d = MAG_OPEN_RST;
    end
    if (st_q == MAG_ST_BOOT) begin
      open_d = MAG_OPEN_RST;
    end
    if (viol && errcnt_q != 8'h00) begin
      errcnt_d = errcnt_q - 8'h01;
    end
    ist_d = ist_q;
    if (reg_wr_in && reg_addr_in == MAG_REG_IRQ_STAT) begin
      ist_d = ist_q & ~reg_wdata_in[MAG_NEV-1:0];
    end
    ist_d = ist_d | ev;
    sreset_d = viol;
    // forbidden sfr reads return zero
    sfrd_d = (acc_in.valid && acc_in.sfr && !acc_in.write && !viol) ?
             sfr_rdata_in : 8'h00;
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        MAG_REG_OPEN: rdata_d = {4'h0, open_q};
        MAG_REG_FIREWALL: rdata_d = {4'h0, fw_q};
        MAG_REG_SECCTL: rdata_d = secctl_q;
        MAG_REG_STATUS: rdata_d = {4'h0, st_q, mode_q};
        MAG_REG_IRQ_STAT: rdata_d = {4'h0, ist_q};
        MAG_REG_IRQ_MASK: rdata_d = {4'h0, imask_q};
        MAG_REG_ERRCNT: rdata_d = errcnt_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      open_q <= MAG_OPEN_RST;
      fw_q <= MAG_FIREWALL_RST;
      secctl_q <= MAG_SECCTL_RST;
      imask_q <= '0;
      ist_q <= '0;
      sreset_q <= 1'b0;
      rdata_q <= 8'h00;
      sfrd_q <= 8'h00;
    end else if (clk_en_in) begin
      open_q <= open_d;
      fw_q <= fw_d;
      secctl_q <= secctl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      sreset_q <= sreset_d;
      rdata_q <= rdata_d;
      sfrd_q <= sfrd_d;
    end
  end

  // counter of security resets: it only counts down and stops at zero
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      errcnt_q <= MAG_ERRCNT_RST;
    end else if (clk_en_in) begin
      errcnt_q <= errcnt_d;
    end
  end

  assign mode_out = mode_q;
  assign test_run_out = (st_q == MAG_ST_TEST);
  assign app_run_out = (st_q == MAG_ST_APP);
  assign secctl_out = secctl_q;
  assign sec_reset_out = sreset_q;
  assign irq_out = |(ist_q & imask_q);
  assign reg_rdata_out = rdata_q;
  assign sfr_rdata_out = sfrd_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_boot_exit_test;
    (st_q == MAG_ST_BOOT) && boot_done_in && test_req_in &&
      !delivery_fuse_in && clk_en_in;
  endsequence

  sequence s_violation;
    viol && clk_en_in;
  endsequence

  AST_TEST_SYS: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    s_boot_exit_test |=> test_run_out && mode_out == MAG_MODE_SYSTEM)
    else $error("test boot did not enter privileged test mode");

  AST_APP_START: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    (st_q == MAG_ST_BOOT) && boot_done_in && !test_req_in && clk_en_in
    |=> app_run_out && mode_out != MAG_MODE_SUPER)
    else $error("application start wrong");

  AST_FUSE_LOCK: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    delivery_fuse_in && st_q == MAG_ST_BOOT |=> !test_run_out)
    else $error("test started despite delivery fuse");

  AST_APP_NO_SUPER: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    app_run_out |-> mode_out != MAG_MODE_SUPER)
    else $error("application at boot level");

  AST_SECCTL_LOCK: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    mode_out != MAG_MODE_SUPER |=> $stable(secctl_out))
    else $error("security control changed outside boot");

  AST_USER_FUSE: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    mode_out == MAG_MODE_USER |=> $stable(secctl_out) && $stable(fw_q))
    else $error("unprivileged mode changed security settings");

  AST_BOOT_CLOSED: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    st_q == MAG_ST_BOOT && clk_en_in |=> open_q == MAG_OPEN_RST)
    else $error("open settings not closed during boot");

  AST_ERR_CLOSE: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    s_violation |=> open_q == MAG_OPEN_RST && sec_reset_out)
    else $error("violation did not close settings and reset");

  AST_REQ_ONLY_VIOL: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    !viol && clk_en_in |=> !sec_reset_out)
    else $error("reset requested without a violation");

  AST_SEG_GATE: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && !acc_in.sfr && mode_out != MAG_MODE_SUPER &&
    seg != 2'h0 && !open_q[seg] |-> !acc_grant_out)
    else $error("closed segment access granted");

  AST_FIREWALL: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && !acc_in.sfr && fw_q[seg] |-> !acc_grant_out)
    else $error("firewall blocked access granted");

  AST_RANGE: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && !acc_in.sfr && acc_in.addr > MAG_MEM_TOP
    |-> !acc_grant_out)
    else $error("out of range access granted");

  AST_CONS: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && (acc_in.addr ^ acc_in.addr_chk) != 16'hffff
    |-> !acc_grant_out)
    else $error("inconsistent address granted");

  AST_SFR_USER: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && acc_in.sfr && acc_in.addr[3] &&
    mode_out == MAG_MODE_USER |-> !acc_grant_out)
    else $error("privileged sfr reached from unprivileged mode");

  AST_SFR_ZERO: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    acc_in.valid && acc_in.sfr && !sfr_ok && clk_en_in
    |=> sfr_rdata_out == 8'h00 && sec_reset_out)
    else $error("forbidden sfr read leaked data");

  AST_ERRCNT: assert property
    (@(posedge clock_in) disable iff (!rst_n_q)
    viol && clk_en_in && errcnt_q != 8'h00
    |=> errcnt_q == $past(errcnt_q) - 8'h01)
    else $error("error counter not decremented");

endmodule : mag_guard
`default_nettype wire

// *** pkg/mag_pkg.sv ***
/*
  mode and access guard: shared constants, types and register map.
  assumes a single 10 MHz clock and a simple strobe register port.
*/
`default_nettype none
package mag_pkg;

  // ------------------------------------------------------------------
  // privilege modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MAG_MODE_USER,
    MAG_MODE_SYSTEM,
    MAG_MODE_SUPER
  } mag_mode_t;

  typedef enum logic [1:0] {
    MAG_ST_BOOT,
    MAG_ST_TEST,
    MAG_ST_APP
  } mag_state_t;

  // ------------------------------------------------------------------
  // access carrier from the core
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        sfr;
    logic [15:0] addr;
    logic [15:0] addr_chk;
  } mag_access_t;

  // ------------------------------------------------------------------
  // memory map and segment layout
  // ------------------------------------------------------------------
  localparam int MAG_NSEG = 4;
  localparam logic [15:0] MAG_MEM_TOP = 16'hbfff;
  localparam logic [1:0] MAG_SEG_SHIFT_HI = 2'h3;
  localparam logic [15:0] MAG_SFR_BASE = 16'hff00;
  localparam logic [7:0] MAG_SFR_LAST = 8'h0f;
  localparam logic [7:0] MAG_SFR_PRIV_FIRST = 8'h08;

  // ------------------------------------------------------------------
  // software register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] MAG_REG_OPEN = 4'h0;
  localparam logic [3:0] MAG_REG_FIREWALL = 4'h1;
  localparam logic [3:0] MAG_REG_SECCTL = 4'h2;
  localparam logic [3:0] MAG_REG_STATUS = 4'h3;
  localparam logic [3:0] MAG_REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] MAG_REG_IRQ_MASK = 4'h5;
  localparam logic [3:0] MAG_REG_ERRCNT = 4'h6;

  // ------------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [3:0] MAG_OPEN_RST = 4'h0;
  localparam logic [3:0] MAG_FIREWALL_RST = 4'h0;
  localparam logic [7:0] MAG_SECCTL_RST = 8'hff;
  localparam logic [7:0] MAG_ERRCNT_RST = 8'hff;
  localparam int MAG_EV_RANGE = 0;
  localparam int MAG_EV_CONS = 1;
  localparam int MAG_EV_SEG = 2;
  localparam int MAG_EV_SFR = 3;
  localparam int MAG_NEV = 4;

endpackage : mag_pkg
`default_nettype wire

// *** test/mag_core_model.sv ***
/*
  processor core model: puts one access on the guard's access carrier
  and answers sfr reads from a small behavioural sfr file.
  assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mag_core_model
  import mag_pkg::*;
(
  // clock
  input wire logic clock_in,
  // towards the guard
  output var mag_access_t acc_out,
  output logic [7:0] sfr_rdata_out
);
  logic [7:0] junk_q = 8'h5a;

  initial acc_out = '0;

  // -----------------------------------------------------------------
  // sfr file: idle data lines wander every cycle
  // -----------------------------------------------------------------
  always @(posedge clock_in) junk_q <= junk_q + 8'h35;

  always_comb begin
    if (acc_out.valid && acc_out.sfr && !acc_out.write) begin
      sfr_rdata_out = {acc_out.addr[3:0], ~acc_out.addr[3:0]};
    end else begin
      sfr_rdata_out = junk_q;
    end
  end

  // -----------------------------------------------------------------
  // bus tasks
  // -----------------------------------------------------------------
  task automatic issue(input mag_access_t a);
    acc_out <= a;
  endtask : issue

  // released bus shows inverted leftovers, not the last access
  task automatic release_bus();
    acc_out <= '{1'b0, ~acc_out.write, ~acc_out.sfr, ~acc_out.addr,
                 acc_out.addr};
  endtask : release_bus
endmodule : mag_core_model
`default_nettype wire

// *** test/test_mag_guard.sv ***
/*
  self-checking bench for the mode and access guard: boot modes,
  register port, random accesses, interrupt and error counter.
  assumes the core model in mag_core_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module test_mag_guard;
  import mag_pkg::*;
  logic clock_in, arst_n_in, boot_done_in, test_req_in, delivery_fuse_in;
  logic app_system_in, reg_wr_in, reg_rd_in, acc_grant_out, test_run_out;
  logic app_run_out, sec_reset_out, irq_out, clk_en_in;
  logic [7:0] fuse_cfg_in, sfr_rdata_in, sfr_rdata_out, reg_wdata_in;
  logic [7:0] reg_rdata_out, secctl_out, sec_e, d;
  logic [3:0] reg_addr_in, op, fw;
  logic [1:0] md;
  mag_access_t acc;
  mag_mode_t mode_out;
  int err_count, compares, nviol;

  mag_core_model u_mag_core_model (.clock_in(clock_in), .acc_out(acc),
    .sfr_rdata_out(sfr_rdata_in));
  mag_guard u_mag_guard (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in), .boot_done_in(boot_done_in),
    .test_req_in(test_req_in), .delivery_fuse_in(delivery_fuse_in),
    .app_system_in(app_system_in), .fuse_cfg_in(fuse_cfg_in),
    .acc_in(acc), .sfr_rdata_in(sfr_rdata_in),
    .sfr_rdata_out(sfr_rdata_out), .acc_grant_out(acc_grant_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .mode_out(mode_out),
    .test_run_out(test_run_out), .app_run_out(app_run_out),
    .secctl_out(secctl_out), .sec_reset_out(sec_reset_out),
    .irq_out(irq_out));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // -----------------------------------------------------------------
  // checking and expectations
  // -----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic viol(input logic [15:0] a, c, input logic s,
                                input logic w);
    if (c !== ~a) return 1'b1;
    if (s) return a[15:8] != 8'hff || a[7:0] > 8'h0f ||
                  (md == 2'h0 && (a[3] || w));
    if (a > 16'hbfff || fw[a[15:14]]) return 1'b1;
    return a[15:14] != 2'h0 && md != 2'h2 && !op[a[15:14]];
  endfunction : viol

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // -----------------------------------------------------------------
  // drivers
  // -----------------------------------------------------------------
  task automatic rw(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= dat;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    if (a == MAG_REG_OPEN && md != 2'h0) op = dat[3:0];
    if (a == MAG_REG_FIREWALL && md == 2'h2) fw = dat[3:0];
    @(negedge clock_in);
  endtask : rw

  task automatic rr(input string nm, input logic [3:0] a,
                    input logic [7:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    check(nm, reg_rdata_out, e);
  endtask : rr

  task automatic acc_go(input logic [15:0] a, input logic s, w, bad);
    mag_access_t r;
    logic v;
    r = '{1'b1, w, s, a, bad ? a : ~a};
    v = viol(r.addr, r.addr_chk, s, w);
    @(posedge clock_in);
    u_mag_core_model.issue(r);
    @(negedge clock_in);
    check("grant", {7'h0, acc_grant_out}, {7'h0, !v});
    @(posedge clock_in);
    u_mag_core_model.release_bus();
    @(negedge clock_in);
    check("sec_reset", {7'h0, sec_reset_out}, {7'h0, v});
    if (s && !w) begin
      check("sfr_data", sfr_rdata_out, v ? 8'h00 : {a[3:0], ~a[3:0]});
    end
    if (v) begin
      nviol++;
      op = 4'h0;
    end
  endtask : acc_go

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {arst_n_in, boot_done_in, test_req_in, delivery_fuse_in} = '0;
    {app_system_in, reg_wr_in, reg_rd_in, reg_addr_in} = '0;
    {fuse_cfg_in, reg_wdata_in} = '0;
    clk_en_in = 1'b1;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h421b));
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      arst_n_in <= 1'b0;
      boot_done_in <= 1'b0;
      {test_req_in, delivery_fuse_in, app_system_in} <= 3'(12'hcc4 >> 3*k);
      fuse_cfg_in <= 8'($urandom);
      repeat (12) @(posedge clock_in);
      arst_n_in <= 1'b1;
      op = 4'h0;
      fw = 4'h0;
      md = 2'h2;
      nviol = 0;
      repeat (3) @(posedge clock_in);
      @(negedge clock_in);
      check("mode", {6'h0, mode_out}, 8'h02);
      rr("open", MAG_REG_OPEN, 8'h00);
      d = 8'($urandom);
      sec_e = d & fuse_cfg_in;
      rw(MAG_REG_SECCTL, d);
      check("secctl", secctl_out, sec_e);
      rw(MAG_REG_FIREWALL, (k == 0) ? 8'h02 : 8'h00);
      acc_go(16'h4000, 1'b0, 1'b0, 1'b0);
      @(posedge clock_in);
      clk_en_in <= 1'b0;
      boot_done_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      @(negedge clock_in);
      check("frozen", {4'h0, test_run_out, app_run_out, mode_out},
            8'h02);
      @(posedge clock_in);
      clk_en_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      md = (k == 0 || k == 2) ? 2'h1 : 2'h0;
      @(negedge clock_in);
      check("mode", {6'h0, mode_out}, {6'h0, md});
      check("test_run", {7'h0, test_run_out}, {7'h0, k == 0});
      check("app_run", {7'h0, app_run_out}, {7'h0, k != 0});
      rr("status", MAG_REG_STATUS, {4'h0, (k == 0) ? 2'h1 : 2'h2, md});
      rw(MAG_REG_SECCTL, 8'h00);
      check("secctl", secctl_out, sec_e);
      rw(MAG_REG_FIREWALL, 8'h0f);
      if (md != 2'h0) begin
        rw(MAG_REG_OPEN, 8'h02);
        acc_go(16'h4123, 1'b0, 1'b1, 1'b0);
        rw(MAG_REG_OPEN, 8'h00);
        acc_go(16'h4123, 1'b0, 1'b0, 1'b0);
      end
      for (int i = 0; i < 40; i++) begin
        if ($urandom % 5 == 0) begin
          rw(MAG_REG_OPEN, 8'($urandom));
          rr("open", MAG_REG_OPEN, {4'h0, op});
        end else if ($urandom % 3 == 0) begin
          acc_go({($urandom % 4 == 0) ? 8'hfe : 8'hff, 3'h0, 5'($urandom)},
                 1'b1, 1'($urandom), 1'($urandom % 8 == 0));
        end else begin
          acc_go(16'($urandom), 1'b0, 1'($urandom),
                 1'($urandom % 8 == 0));
        end
      end
      rr("errcnt", MAG_REG_ERRCNT, 8'hff - 8'(nviol));
      if (md != 2'h0) begin
        rw(MAG_REG_IRQ_STAT, 8'h0f);
        acc_go(16'h0010, 1'b0, 1'b0, 1'b1);
        check("irq", {7'h0, irq_out}, 8'h00);
        rr("irq_stat", MAG_REG_IRQ_STAT, 8'h02);
        rw(MAG_REG_IRQ_MASK, 8'h02);
        check("irq", {7'h0, irq_out}, 8'h01);
        rw(MAG_REG_IRQ_STAT, 8'h02);
        check("irq", {7'h0, irq_out}, 8'h00);
        rr("irq_stat", MAG_REG_IRQ_STAT, 8'h00);
      end
    end
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    end_of_test();
  end
endmodule : test_mag_guard
`default_nettype wire
